// ---- fps_regs.vh ----
`ifndef FPS_REGS_VH
`define FPS_REGS_VH
// register byte offsets
`define FPS_CTRL_ADDR      5'h00
`define FPS_LEVEL_A_ADDR   5'h04
`define FPS_LEVEL_B_ADDR   5'h08
`define FPS_LEVEL_C_ADDR   5'h0C
`define FPS_RESTART_ADDR   5'h10
`define FPS_STATUS_ADDR    5'h14
`define FPS_CAUSE_ADDR     5'h18
// ctrl fields
`define FPS_CTRL_UV_EN     0
`define FPS_CTRL_OV_EN     1
`define FPS_CTRL_PK_EN     2
`define FPS_CTRL_SPEED     3
`define FPS_CTRL_FIXPER    4
`define FPS_CTRL_RESET     32'h0000_0007
// reset values of levels
`define FPS_LEVEL_A_RESET  32'h0000_0000
`define FPS_LEVEL_B_RESET  32'hFFFF_FFFF
`define FPS_LEVEL_C_RESET  32'h0000_00FF
`define FPS_RESTART_RESET  32'h00A0_0008
// timing
`define FPS_CLK_MHZ        200
`define FPS_HALF_PERIOD_NS 9823000
`define FPS_HP_CYC         ((`FPS_HALF_PERIOD_NS * `FPS_CLK_MHZ) / 1000)
`define FPS_GD_OFF_CYC     ((`FPS_HP_CYC) / 512)
`define FPS_FAST_WAIT_MS   400
`define FPS_FAST_HP        ((`FPS_FAST_WAIT_MS * 1000000) / `FPS_HALF_PERIOD_NS)
`define FPS_UV_BLANK_HP    10
`define FPS_OV_BLANK_HP    1
`define FPS_SLOW_SAMPLE_HP 7
`define FPS_TEMP_MARGIN    8'h04
// reaction codes, ascending severity
`define FPS_RX_NONE        3'd0
`define FPS_RX_FAST        3'd1
`define FPS_RX_AUTO        3'd2
`define FPS_RX_LATCH       3'd3
`define FPS_RX_STOP        3'd4
`endif

// ---- fps_supervisor.v ----
// Contract
// - demag too short over half a line half-period: auto-restart
// - half-period fixed 9.823 ms or measured line period; input trip blanking counts it, peak blanking counts current samples
// - peak output current over limit beyond blanking, when enabled: auto-restart
// - peak current restart waits 0.4 s when fast, restart delay when slow
// - pre-startup input below min or above max start level, when that guard is enabled: no start, auto-restart
// - input below low trip level ten half-periods, when enabled: auto-restart
// - input above high trip level one half-period, when enabled: auto-restart
// - supply lockout with on and off thresholds, hysteresis
// - supply sampled every seven half-periods, over level: auto-restart
// - temperature sampled every seven half-periods; start only 4 C below critical
// - open current-sense input held high: auto-restart
// - converter samples missing in window: fast auto-restart
// - hardware watchdog not serviced: auto-restart
// - memory parity error: auto-restart
// - startup integrity check mismatch: stop mode
// - task watchdog: auto-restart
// - empty parameter store at startup: stop mode
// - no zero-crossing sense signal at startup: stop mode
// - gate driver off within 1/512 half-period of any trigger
// - latch holds until supply falls below turn-off level; no fault selects the latch reaction here, so latched_out stays low
// - auto-restart waits restart delay, fast waits 0.4 s, in low-power wait
// - after wait: discharge pulse, recharge, pre-startup check, start, regulate
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "fps_regs.vh"
module fps_supervisor (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [7:0]  vin_est,
   input  wire [7:0]  iout_est,
   input  wire        iout_sample,
   input  wire [7:0]  supply_level,
   input  wire [7:0]  junction_temp,
   input  wire        line_edge,
   input  wire        demag_short,
   input  wire        cs_open,
   input  wire        zero_crossing_sense_input,
   input  wire        conv_timeout,
   input  wire        hw_wdog_expired,
   input  wire        parity_error,
   input  wire        crc_fail,
   input  wire        task_wdog_fault,
   input  wire        param_empty,
   input  wire        supply_above_on,
   input  wire        supply_below_off,
   input  wire        recharge_done,
   output reg         gate_enable,
   output reg         discharge_pulse,
   output reg         low_power_wait_state,
   output reg         latched_out,
   output reg         stopped_out
);
   localparam ST_OFF   = 3'd0;
   localparam ST_CHECK = 3'd1;
   localparam ST_RUN   = 3'd2;
   localparam ST_GDOFF = 3'd3;
   localparam ST_WAIT  = 3'd4;
   localparam ST_DISCH = 3'd5;
   localparam ST_RECH  = 3'd6;
   localparam ST_HOLD  = 3'd7;
   localparam [31:0] HP_FIXED = `FPS_HP_CYC;
   localparam [31:0] GD_FULL  = `FPS_GD_OFF_CYC;
   localparam [31:0] FAST_FULL = `FPS_FAST_HP;
   localparam [15:0] GD_CYC   = GD_FULL[15:0];
   localparam [7:0]  FAST_HP  = FAST_FULL[7:0];

   // three-stage input sync; change once stages 2 and 3 agree
   localparam NS = 15;
   wire [NS-1:0] raw_in = {line_edge, demag_short, cs_open, zero_crossing_sense_input, conv_timeout,
                           hw_wdog_expired, parity_error, crc_fail, task_wdog_fault, param_empty,
                           supply_above_on, supply_below_off, recharge_done, iout_sample, 1'b0};
   reg  [NS-1:0] s1_q, s2_q, s3_q, sv_q;
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               sv_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw_in[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  sv_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate
   wire y_line = sv_q[14], y_demag = sv_q[13], y_csopen = sv_q[12], y_zcd = sv_q[11];
   wire y_conv = sv_q[10], y_hwdog = sv_q[9], y_par = sv_q[8], y_crc = sv_q[7];
   wire y_task = sv_q[6], y_empty = sv_q[5], y_on = sv_q[4], y_off = sv_q[3];
   wire y_rech = sv_q[2], y_isamp = sv_q[1];
   reg  line_d_q, isamp_d_q;

   // registers
   reg [31:0] ctrl_q, lvl_a_q, lvl_b_q, lvl_c_q, rst_cfg_q;
   reg [7:0]  cause_q;
   reg [2:0]  state_q;
   reg [2:0]  rx_q;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
   endfunction

   // axi4-lite write: address and data taken in any order
   reg        aw_have_q, w_have_q;
   reg [4:0]  aw_q;
   reg [31:0] wd_q;
   reg [3:0]  ws_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_q <= 5'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         ctrl_q    <= `FPS_CTRL_RESET;
         lvl_a_q   <= `FPS_LEVEL_A_RESET;
         lvl_b_q   <= `FPS_LEVEL_B_RESET;
         lvl_c_q   <= `FPS_LEVEL_C_RESET;
         rst_cfg_q <= `FPS_RESTART_RESET;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr[4:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (aw_q)
               `FPS_CTRL_ADDR:    ctrl_q    <= merge(ctrl_q, wd_q, ws_q);
               `FPS_LEVEL_A_ADDR: lvl_a_q   <= merge(lvl_a_q, wd_q, ws_q);
               `FPS_LEVEL_B_ADDR: lvl_b_q   <= merge(lvl_b_q, wd_q, ws_q);
               `FPS_LEVEL_C_ADDR: lvl_c_q   <= merge(lvl_c_q, wd_q, ws_q);
               `FPS_RESTART_ADDR: rst_cfg_q <= merge(rst_cfg_q, wd_q, ws_q);
               `FPS_STATUS_ADDR, `FPS_CAUSE_ADDR: s_axi_bresp <= 2'h0;
               default:           s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr[4:0])
               `FPS_CTRL_ADDR:    s_axi_rdata <= ctrl_q;
               `FPS_LEVEL_A_ADDR: s_axi_rdata <= lvl_a_q;
               `FPS_LEVEL_B_ADDR: s_axi_rdata <= lvl_b_q;
               `FPS_LEVEL_C_ADDR: s_axi_rdata <= lvl_c_q;
               `FPS_RESTART_ADDR: s_axi_rdata <= rst_cfg_q;
               `FPS_STATUS_ADDR:  s_axi_rdata <= {26'h0, rx_q, state_q};
               `FPS_CAUSE_ADDR:   s_axi_rdata <= {24'h0, cause_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // level fields
   wire [7:0] input_low_trip_level  = lvl_a_q[7:0];
   wire [7:0] vin_start_min         = lvl_a_q[15:8];
   wire [7:0] input_high_trip_level = lvl_b_q[7:0];
   wire [7:0] vin_start_max         = lvl_b_q[15:8];
   wire [7:0] iout_peak_level       = lvl_a_q[23:16];
   wire [7:0] supply_max_level      = lvl_b_q[23:16];
   wire [7:0] temp_critical         = lvl_c_q[7:0];
   wire [7:0] peak_blank_cyc        = lvl_c_q[15:8];
   wire [7:0] restart_delay_hp      = rst_cfg_q[7:0];
   wire [15:0] discharge_pulse_width = rst_cfg_q[31:16];
   wire input_low_guard_enable  = ctrl_q[`FPS_CTRL_UV_EN];
   wire input_high_guard_enable = ctrl_q[`FPS_CTRL_OV_EN];
   wire peak_enable             = ctrl_q[`FPS_CTRL_PK_EN];
   wire peak_current_restart_speed = ctrl_q[`FPS_CTRL_SPEED];
   wire fixed_period            = ctrl_q[`FPS_CTRL_FIXPER];

   // half-period tick: fixed count or measured line edge
   reg  [31:0] hp_cnt_q;
   reg  [31:0] hp_len_q;
   reg         hp_tick_q;
   reg  [31:0] demag_cnt_q;
   wire line_rise = y_line && !line_d_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hp_cnt_q <= 32'h0000_0000;
         hp_len_q <= HP_FIXED;
         hp_tick_q <= 1'b0;
         line_d_q <= 1'b0;
         isamp_d_q <= 1'b0;
      end else begin
         line_d_q <= y_line;
         isamp_d_q <= y_isamp;
         if (!fixed_period && line_rise)
            hp_len_q <= hp_cnt_q + 32'h1;
         if (fixed_period ? (hp_cnt_q >= HP_FIXED - 32'h1) : line_rise) begin
            hp_cnt_q <= 32'h0000_0000;
            hp_tick_q <= 1'b1;
         end else begin
            hp_cnt_q <= hp_cnt_q + 32'h1;
            hp_tick_q <= 1'b0;
         end
      end
   end

   // blanking counters and fault detection
   reg [3:0]  uv_hp_q, ov_hp_q;
   reg [2:0]  seven_q;
   reg [7:0]  pk_q;
   reg        f_demag_q, f_pk_q, f_uv_q, f_ov_q, f_sup_q, f_tmp_q;
   wire running = (state_q == ST_RUN);
   wire sample7 = hp_tick_q && (seven_q == 3'd6);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         uv_hp_q <= 4'h0;
         ov_hp_q <= 4'h0;
         seven_q <= 3'h0;
         pk_q <= 8'h00;
         demag_cnt_q <= 32'h0000_0000;
         {f_demag_q, f_pk_q, f_uv_q, f_ov_q, f_sup_q, f_tmp_q} <= 6'h00;
      end else begin
         if (hp_tick_q)
            seven_q <= (seven_q == 3'd6) ? 3'd0 : seven_q + 3'd1;
         demag_cnt_q <= hp_tick_q ? 32'h0 : (y_demag && running ? demag_cnt_q + 32'h1 : demag_cnt_q);
         f_demag_q <= running && (demag_cnt_q > ((fixed_period ? HP_FIXED : hp_len_q) >> 1));
         if (!running || !(input_low_guard_enable && vin_est < input_low_trip_level))
            uv_hp_q <= 4'h0;
         else if (hp_tick_q && uv_hp_q != 4'hF)
            uv_hp_q <= uv_hp_q + 4'h1;
         f_uv_q <= uv_hp_q >= `FPS_UV_BLANK_HP;
         if (!running || !(input_high_guard_enable && vin_est > input_high_trip_level))
            ov_hp_q <= 4'h0;
         else if (hp_tick_q && ov_hp_q != 4'hF)
            ov_hp_q <= ov_hp_q + 4'h1;
         f_ov_q <= ov_hp_q >= `FPS_OV_BLANK_HP;
         if (!running || !peak_enable)
            pk_q <= 8'h00;
         else if (y_isamp && !isamp_d_q)
            pk_q <= (iout_est > iout_peak_level) ? ((pk_q == 8'hFF) ? pk_q : pk_q + 8'h01) : 8'h00;
         f_pk_q <= running && peak_enable && (pk_q > peak_blank_cyc);
         f_sup_q <= running && sample7 && (supply_level > supply_max_level);
         f_tmp_q <= running && sample7 && (junction_temp > temp_critical);
      end
   end

   // reaction priority
   wire run_faults = f_demag_q | f_pk_q | f_uv_q | f_ov_q | f_sup_q | f_tmp_q;
   wire auto_hit = running && (run_faults | y_csopen | y_hwdog | y_par | y_task);
   wire fast_hit = running && y_conv;
   wire stop_hit = (state_q == ST_CHECK) && (y_crc | y_empty | !y_zcd);
   wire [2:0] rx_new = stop_hit ? `FPS_RX_STOP :
                       auto_hit ? `FPS_RX_AUTO :
                       fast_hit ? `FPS_RX_FAST : `FPS_RX_NONE;
   wire pk_fast = f_pk_q && peak_current_restart_speed && !(run_faults & ~f_pk_q) &&
                  !(y_csopen | y_hwdog | y_par | y_task);
   wire temp_ok = junction_temp < (temp_critical - `FPS_TEMP_MARGIN);
   wire vin_bad = (input_low_guard_enable && vin_est < vin_start_min) ||
                  (input_high_guard_enable && vin_est > vin_start_max);

   // restart sequencer
   reg [15:0] tmr_q;
   reg [7:0]  wait_hp_q;
   reg [7:0]  wait_len_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_OFF;
         rx_q <= `FPS_RX_NONE;
         cause_q <= 8'h00;
         tmr_q <= 16'h0000;
         wait_hp_q <= 8'h00;
         wait_len_q <= 8'h00;
         gate_enable <= 1'b0;
         discharge_pulse <= 1'b0;
         low_power_wait_state <= 1'b0;
         latched_out <= 1'b0;
         stopped_out <= 1'b0;
      end else begin
         case (state_q)
            ST_OFF: begin
               gate_enable <= 1'b0;
               latched_out <= 1'b0;
               if (y_on && !y_off)
                  state_q <= ST_CHECK;
            end
            ST_CHECK: begin
               if (stop_hit) begin
                  rx_q <= rx_new;
                  cause_q <= {5'h0, y_crc, y_empty, !y_zcd};
                  state_q <= ST_HOLD;
                  stopped_out <= 1'b1;
                  gate_enable <= 1'b0;
               end else if (vin_bad || !temp_ok) begin
                  rx_q <= `FPS_RX_AUTO;
                  wait_len_q <= restart_delay_hp;
                  gate_enable <= 1'b0;
                  tmr_q <= 16'h0000;
                  state_q <= ST_GDOFF;
               end else begin
                  gate_enable <= 1'b1;
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rx_new != `FPS_RX_NONE) begin
                  gate_enable <= 1'b0;
                  rx_q <= rx_new;
                  cause_q <= {1'b0, y_conv, f_demag_q, f_pk_q, f_uv_q, f_ov_q, f_sup_q, f_tmp_q};
                  wait_len_q <= (fast_hit && !auto_hit) || pk_fast ?
                                FAST_HP : restart_delay_hp;
                  tmr_q <= 16'h0000;
                  state_q <= ST_GDOFF;
               end
            end
            ST_GDOFF: begin
               tmr_q <= tmr_q + 16'h1;
               if (tmr_q >= GD_CYC - 16'h1) begin
                  low_power_wait_state <= 1'b1;
                  wait_hp_q <= 8'h00;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (hp_tick_q)
                  wait_hp_q <= wait_hp_q + 8'h01;
               if (wait_hp_q >= wait_len_q) begin
                  low_power_wait_state <= 1'b0;
                  discharge_pulse <= 1'b1;
                  tmr_q <= 16'h0000;
                  state_q <= ST_DISCH;
               end
            end
            ST_DISCH: begin
               tmr_q <= tmr_q + 16'h1;
               if (tmr_q + 16'h1 >= discharge_pulse_width) begin
                  discharge_pulse <= 1'b0;
                  state_q <= ST_RECH;
               end
            end
            ST_RECH: begin
               if (y_rech && !y_off)
                  state_q <= ST_CHECK;
            end
            ST_HOLD: begin
               gate_enable <= 1'b0;
               if (rx_q == `FPS_RX_LATCH && y_off) begin
                  latched_out <= 1'b0;
                  state_q <= ST_OFF;
               end
            end
            default: state_q <= ST_OFF;
         endcase
         if (y_off && state_q != ST_OFF && rx_q != `FPS_RX_STOP) begin
            state_q <= ST_OFF;
            gate_enable <= 1'b0;
            low_power_wait_state <= 1'b0;
            discharge_pulse <= 1'b0;
         end
      end
   end
endmodule

// ---- fps_supervisor_sva.sv ----
`timescale 1ns/10ps
module fps_sva (
   input wire clk,
   input wire arst_n,
   input wire cs_open,
   input wire supply_below_off,
   input wire gate_enable,
   input wire discharge_pulse,
   input wire low_power_wait_state,
   input wire latched_out,
   input wire stopped_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_reset_quiet: assert property ($rose(arst_n) |-> !gate_enable && !low_power_wait_state)
      else $error("output active after reset");
   a_gate_off_fast: assert property (gate_enable && cs_open |-> ##[1:12] !gate_enable)
      else $error("gate not off after fault");
   // cycles with gate off and no wait, stop, latch or supply loss
   logic [11:0] gap_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         gap_q <= 12'h000;
      else if (gate_enable || low_power_wait_state || stopped_out || latched_out || supply_below_off)
         gap_q <= 12'h000;
      else
         gap_q <= gap_q + 12'h001;
   end
   a_wait_follows: assert property (gap_q < 12'd4000)
      else $error("no wait after gate off");
   a_pulse_after_wait: assert property ($fell(low_power_wait_state) && !supply_below_off
      |-> ##[0:8] discharge_pulse)
      else $error("no discharge pulse after wait");
   a_pulse_alone: assert property (discharge_pulse |-> !gate_enable && !low_power_wait_state)
      else $error("pulse overlaps gate or wait");
   a_stop_holds: assert property (stopped_out |=> stopped_out)
      else $error("stop mode left");
   a_stop_quiet: assert property (stopped_out |-> !gate_enable && !discharge_pulse)
      else $error("activity in stop mode");
   a_latch_holds: assert property (latched_out && !supply_below_off |=> latched_out && !gate_enable)
      else $error("latch released early");
   c_wait: cover property ($rose(low_power_wait_state));
   c_pulse: cover property ($rose(discharge_pulse));
   c_stop: cover property ($rose(stopped_out));
endmodule
bind fps_supervisor fps_sva u_sva (.clk, .arst_n, .cs_open, .supply_below_off, .gate_enable,
   .discharge_pulse, .low_power_wait_state, .latched_out, .stopped_out);

// ---- fps_stage_model.sv ----
`timescale 1ns/10ps
module fps_stage_model #(
   parameter int HP_CYC   = 64,
   parameter int RECH_CYC = 20
) (
   input  wire  clk,
   input  wire  supply_on,
   input  wire  discharge_pulse,
   output logic line_edge,
   output logic recharge_done,
   output logic supply_above_on,
   output logic supply_below_off
);
   int hp_cnt = 0;
   int rech = 0;
   initial {line_edge, recharge_done, supply_above_on, supply_below_off} = 4'b0001;
   // free-running rectified line marker, supply recharge after each pulse
   always @(posedge clk) begin
      hp_cnt <= (hp_cnt == HP_CYC - 1) ? 0 : hp_cnt + 1;
      line_edge <= (hp_cnt < 4);
      rech <= discharge_pulse ? RECH_CYC : (rech > 0 ? rech - 1 : 0);
      recharge_done <= supply_on && rech == 0 && !discharge_pulse;
      supply_above_on <= supply_on;
      supply_below_off <= !supply_on;
   end
endmodule

// ---- tb_fps.sv ----
`timescale 1ns/10ps
`include "fps_regs.vh"
module tb;
   localparam int GATE = 0, PULSE = 1, LPW = 2, STOP = 4;
   logic        clk, arst_n, supply_on, iout_sample, line_edge, recharge_done;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  vin_est, iout_est, supply_level, junction_temp;
   logic        demag_short, cs_open, zero_crossing_sense_input, conv_timeout, hw_wdog_expired;
   logic        parity_error, crc_fail, task_wdog_fault, param_empty, supply_above_on, supply_below_off;
   logic        gate_enable, discharge_pulse, low_power_wait_state, latched_out, stopped_out;
   wire  [4:0]  outs = {stopped_out, latched_out, low_power_wait_state, discharge_pulse, gate_enable};
   int          fails = 0, num_checks = 0, c;
   fps_supervisor uut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vin_est, .iout_est, .iout_sample,
      .supply_level, .junction_temp, .line_edge, .demag_short, .cs_open, .zero_crossing_sense_input, .conv_timeout,
      .hw_wdog_expired, .parity_error, .crc_fail, .task_wdog_fault, .param_empty, .supply_above_on,
      .supply_below_off, .recharge_done, .gate_enable, .discharge_pulse, .low_power_wait_state, .latched_out,
      .stopped_out);
   fps_stage_model #(.HP_CYC(64), .RECH_CYC(20)) u_stage (.clk, .supply_on, .discharge_pulse, .line_edge,
      .recharge_done, .supply_above_on, .supply_below_off);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wt(input string n, input int b, input logic v, input int lim, output int k);
      k = 0;
      while (outs[b] !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk(n, 32'(v), 32'(outs[b]));
   endtask
   task automatic setf(input int id, input logic v);
      case (id)
         0: cs_open <= v;
         1: hw_wdog_expired <= v;
         2: parity_error <= v;
         3: task_wdog_fault <= v;
         4: demag_short <= v;
         5: conv_timeout <= v;
         6: iout_est <= v ? 8'hF0 : 8'h40;
         7: vin_est <= v ? 8'h20 : 8'h80;
         8: vin_est <= v ? 8'hF0 : 8'h80;
         9: supply_level <= v ? 8'hF0 : 8'h80;
         10: junction_temp <= v ? 8'h90 : 8'h50;
         11: crc_fail <= v;
         12: param_empty <= v;
         13: zero_crossing_sense_input <= !v;
         default: {cs_open, conv_timeout} <= {v, v};
      endcase
   endtask
   task automatic t_regs();
      logic [31:0] rv [5] = '{`FPS_CTRL_RESET, `FPS_LEVEL_A_RESET, `FPS_LEVEL_B_RESET, `FPS_LEVEL_C_RESET,
         `FPS_RESTART_RESET};
      logic [31:0] cv [4] = '{32'h00C0_5040, 32'h00E0_B0C0, 32'h0000_0480, 32'h0010_0008};
      for (int i = 0; i < 5; i++) begin
         axr(32'(i * 4), rd, rs);
         chk("reset value", rv[i], rd);
      end
      axr(32'h1C, rd, rs);
      chk("unmapped rresp", 32'h2, 32'(rs));
      chk("unmapped rdata", 32'h0, rd);
      axw(32'h1C, 32'h5, rs);
      chk("unmapped bresp", 32'h2, 32'(rs));
      axw(32'(`FPS_STATUS_ADDR), 32'hFF, rs);
      chk("status bresp", 32'h0, 32'(rs));
      for (int i = 0; i < 4; i++) begin
         axw(32'((i + 1) * 4), cv[i], rs);
         axr(32'((i + 1) * 4), rd, rs);
         chk("readback", cv[i], rd);
      end
   endtask
   task automatic t_fault(input int id, input logic [31:0] ctl, input int ehp);
      int hp;
      logic le;
      axw(32'(`FPS_CTRL_ADDR), ctl, rs);
      setf(id, 1'b1);
      wt("gate off", GATE, 1'b0, 3000, c);
      wt("wait on", LPW, 1'b1, 5000, c);
      setf(id, 1'b0);
      hp = 0;
      le = line_edge;
      while (low_power_wait_state === 1'b1) begin
         @(posedge clk);
         if (line_edge && !le) hp++;
         le = line_edge;
      end
      chk("wait half periods", 32'd1, 32'(hp >= ehp - 1 && hp <= ehp + 1));
      wt("pulse on", PULSE, 1'b1, 20, c);
      wt("pulse off", PULSE, 1'b0, 1000, c);
      chk("pulse width", 32'd16, 32'(c));
      wt("restart", GATE, 1'b1, 20000, c);
   endtask
   task automatic t_prestart(input int k, input logic [7:0] v);
      if (k == 0) vin_est <= v;
      else junction_temp <= v;
      setf(0, 1'b1);
      wt("gate off", GATE, 1'b0, 3000, c);
      wt("wait on", LPW, 1'b1, 5000, c);
      setf(0, 1'b0);
      wt("wait off", LPW, 1'b0, 5000, c);
      wt("no start", LPW, 1'b1, 8000, c);
      {vin_est, junction_temp} <= 16'h8050;
      wt("restart", GATE, 1'b1, 20000, c);
   endtask
   task automatic t_stop(input int id);
      arst_n <= 1'b0;
      setf(id, 1'b1);
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      wt("stop", STOP, 1'b1, 20000, c);
      chk("stop gate", 32'd0, 32'(gate_enable));
      setf(id, 1'b0);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always begin
      repeat (4) @(posedge clk);
      iout_sample <= ~iout_sample;
   end
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      wrap_up();
   end
   initial begin
      {arst_n, supply_on, iout_sample, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {demag_short, cs_open, conv_timeout, hw_wdog_expired, parity_error, crc_fail, task_wdog_fault} = '0;
      {param_empty, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_wstrb, zero_crossing_sense_input} = 5'h1F;
      {vin_est, iout_est, supply_level, junction_temp} = 32'h8040_8050;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      supply_on <= 1'b1;
      wt("start", GATE, 1'b1, 20000, c);
      t_fault(0, 32'h7, 8);
      t_fault(1, 32'h7, 8);
      t_fault(2, 32'h7, 8);
      t_fault(3, 32'h7, 8);
      t_fault(4, 32'h7, 8);
      t_fault(5, 32'h7, 40);
      t_fault(6, 32'h7, 8);
      t_fault(6, 32'hF, 40);
      t_fault(7, 32'h7, 8);
      t_fault(8, 32'h7, 8);
      t_fault(9, 32'h7, 8);
      t_fault(10, 32'h7, 8);
      t_fault(14, 32'h7, 8);
      t_prestart(0, 8'h48);
      t_prestart(0, 8'hB8);
      t_prestart(1, 8'h7E);
      supply_on <= 1'b0;
      wt("supply off", GATE, 1'b0, 100, c);
      supply_on <= 1'b1;
      wt("supply on", GATE, 1'b1, 20000, c);
      t_stop(11);
      t_stop(12);
      t_stop(13);
      wrap_up();
   end
endmodule
